// [rtl/relay_pkg.sv]
// Constants and types for the two-channel relay output conditioner
package relay_pkg;

   localparam int NUM_CH = 2;
   localparam int DELAY_W = 16;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned MS_NS = 1000000;
   localparam int unsigned MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WDOG_MS = 500;
   localparam logic [1:0] WDOG_FAILS = 2'h3;

   // ------------------------------------------------------------
   // Output byte layout
   // ------------------------------------------------------------
   localparam int OUT_CH1_BIT = 0;
   localparam int OUT_CH2_BIT = 1;
   localparam logic [7:0] OUT_BYTE_RST = 8'h00;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [1:0] BUS_BITS_RST = 2'h0;
   localparam logic [1:0] BUS_INV_RST = 2'h3;
   localparam logic [1:0] CH_VAL_RST = 2'h0;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ERR_CURRENT = 2'b00,
      ERR_SUBST = 2'b01,
      ERR_LAST = 2'b10
   } err_mode_t;

   typedef enum logic [1:0] {
      WD_OK = 2'b00,
      WD_EXPIRED = 2'b01,
      WD_OFF = 2'b10
   } wd_state_t;

endpackage : relay_pkg

// [rtl/relay_delay_timer.sv]
// ON/OFF delay timer for one channel, counted in millisecond ticks
`timescale 1ns/10ps
`default_nettype none
module relay_delay_timer import relay_pkg::*; #(
   parameter int DLY_W = DELAY_W
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic tick,
   input wire logic din,
   input wire logic [DLY_W-1:0] on_ms,
   input wire logic [DLY_W-1:0] off_ms,
   output logic dout
);

   logic dout_reg;
   logic dout_next;
   logic [DLY_W-1:0] cnt_reg;
   logic [DLY_W-1:0] cnt_next;
   logic [DLY_W-1:0] limit;
   localparam logic [DLY_W-1:0] CNT_ONE = DLY_W'(1);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      limit = din ? on_ms : off_ms;
      dout_next = dout_reg;
      cnt_next = '0;
      if (din != dout_reg) begin
         // Pending change must be held for the full delay, else restart
         if (limit == '0) begin
            dout_next = din;
         end else if (tick) begin
            if (cnt_reg + CNT_ONE >= limit) begin
               dout_next = din;
            end else begin
               cnt_next = cnt_reg + CNT_ONE;
            end
         end else begin
            cnt_next = cnt_reg;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dout_reg <= 1'b0;
         cnt_reg <= '0;
      end else begin
         dout_reg <= dout_next;
         cnt_reg <= cnt_next;
      end
   end

   assign dout = dout_reg;

endmodule : relay_delay_timer
`default_nettype wire

// [rtl/relay_output_conditioner.sv]
// Two-channel relay output conditioner: source, error strategy, negation, delays
`timescale 1ns/10ps
`default_nettype none
module relay_output_conditioner import relay_pkg::*; #(
   parameter int unsigned TICK_CYCLES = MS_CYCLES,
   parameter int DLY_W = DELAY_W
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic module_active,
   input wire logic [7:0] bus_out_byte,
   input wire logic [1:0] bus_invalid,
   input wire logic bus_strobe,
   input wire logic comm_ok,
   input wire logic comm_fail,
   input wire logic [1:0] sim_mode,
   input wire logic [1:0] sim_value,
   input wire logic [1:0] sim_invalid,
   input wire logic [1:0] subst_value,
   input wire logic [3:0] err_mode,
   input wire logic [1:0] negate,
   input wire logic [2*DLY_W-1:0] on_delay_ms,
   input wire logic [2*DLY_W-1:0] off_delay_ms,
   output logic [1:0] relay_out,
   output logic [7:0] out_byte,
   output logic [1:0] channel_active,
   output logic [1:0] err_active,
   output logic watchdog_expired,
   output logic outputs_off
);

   localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
   localparam logic [9:0] WDOG_LAST = 10'(WDOG_MS - 1);

   // Error strategy value for one channel
   function automatic logic strategy_value(input logic [1:0] mode, input logic src,
                                           input logic subst, input logic last);
      logic val;
      val = subst;
      case (mode)
         ERR_CURRENT: val = src;
         ERR_SUBST: val = subst;
         ERR_LAST: val = last;
         default: val = subst;
      endcase
      return val;
   endfunction : strategy_value

   // ------------------------------------------------------------
   // Millisecond tick
   // ------------------------------------------------------------
   logic [TW-1:0] tick_cnt_reg;
   logic [TW-1:0] tick_cnt_next;
   logic tick_reg;
   logic tick_next;

   always_comb begin
      tick_next = 1'b0;
      tick_cnt_next = tick_cnt_reg + TW'(1);
      if (tick_cnt_reg == TICK_LAST) begin
         tick_cnt_next = '0;
         tick_next = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tick_cnt_reg <= '0;
         tick_reg <= 1'b0;
      end else begin
         tick_cnt_reg <= tick_cnt_next;
         tick_reg <= tick_next;
      end
   end

   // ------------------------------------------------------------
   // Communication watchdog
   // ------------------------------------------------------------
   wd_state_t wd_state_reg;
   wd_state_t wd_state_next;
   logic [1:0] fail_cnt_reg;
   logic [1:0] fail_cnt_next;
   logic [9:0] wd_ms_reg;
   logic [9:0] wd_ms_next;

   always_comb begin
      wd_state_next = wd_state_reg;
      fail_cnt_next = fail_cnt_reg;
      wd_ms_next = wd_ms_reg;
      if (comm_ok) begin
         wd_state_next = WD_OK;
         fail_cnt_next = 2'h0;
         wd_ms_next = 10'h000;
      end else begin
         case (wd_state_reg)
            WD_OK: begin
               if (comm_fail) begin
                  if (fail_cnt_reg + 2'h1 == WDOG_FAILS) begin
                     wd_state_next = WD_EXPIRED;
                     wd_ms_next = 10'h000;
                  end else begin
                     fail_cnt_next = fail_cnt_reg + 2'h1;
                  end
               end
            end
            WD_EXPIRED: begin
               if (tick_reg) begin
                  if (wd_ms_reg == WDOG_LAST) begin
                     wd_state_next = WD_OFF;
                  end else begin
                     wd_ms_next = wd_ms_reg + 10'h001;
                  end
               end
            end
            WD_OFF: wd_state_next = WD_OFF;
            default: wd_state_next = WD_OK;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wd_state_reg <= WD_OK;
         fail_cnt_reg <= 2'h0;
         wd_ms_reg <= 10'h000;
      end else begin
         wd_state_reg <= wd_state_next;
         fail_cnt_reg <= fail_cnt_next;
         wd_ms_reg <= wd_ms_next;
      end
   end

   // ------------------------------------------------------------
   // Bus data capture
   // ------------------------------------------------------------
   logic [1:0] bus_bits_reg;
   logic [1:0] bus_bits_next;
   logic [1:0] bus_inv_reg;
   logic [1:0] bus_inv_next;

   always_comb begin
      bus_bits_next = bus_bits_reg;
      bus_inv_next = bus_inv_reg;
      if (bus_strobe) begin
         bus_bits_next = {bus_out_byte[OUT_CH2_BIT], bus_out_byte[OUT_CH1_BIT]};
         bus_inv_next = bus_invalid;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bus_bits_reg <= BUS_BITS_RST;
         bus_inv_reg <= BUS_INV_RST;
      end else begin
         bus_bits_reg <= bus_bits_next;
         bus_inv_reg <= bus_inv_next;
      end
   end

   // ------------------------------------------------------------
   // Channel conditioning
   // ------------------------------------------------------------
   logic [1:0] src;
   logic [1:0] bad;
   logic [1:0] err;
   logic [1:0] cond_reg;
   logic [1:0] cond_next;
   logic [1:0] last_reg;
   logic [1:0] last_next;
   logic [1:0] err_reg;
   logic [1:0] dly_out;
   logic wd_err;

   assign wd_err = (wd_state_reg != WD_OK);

   always_comb begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
         // Line faults have no input here, so they cannot raise an error
         src[ch] = sim_mode[ch] ? sim_value[ch] : bus_bits_reg[ch];
         bad[ch] = sim_mode[ch] ? sim_invalid[ch] : bus_inv_reg[ch];
         err[ch] = bad[ch] | wd_err;
         last_next[ch] = err[ch] ? last_reg[ch] : src[ch];
         cond_next[ch] = (err[ch] ? strategy_value(err_mode[2*ch +: 2], src[ch],
                                                   subst_value[ch], last_reg[ch])
                                  : src[ch]) ^ negate[ch];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cond_reg <= CH_VAL_RST;
         last_reg <= CH_VAL_RST;
         err_reg <= 2'h0;
      end else begin
         cond_reg <= cond_next;
         last_reg <= last_next;
         err_reg <= err;
      end
   end

   for (genvar g = 0; g < NUM_CH; g++) begin : g_dly
      relay_delay_timer #(
         .DLY_W(DLY_W)
      ) u_dly (
         .clk(clk),
         .sys_rst(sys_rst),
         .tick(tick_reg),
         .din(cond_reg[g]),
         .on_ms(on_delay_ms[g*DLY_W +: DLY_W]),
         .off_ms(off_delay_ms[g*DLY_W +: DLY_W]),
         .dout(dly_out[g])
      );
   end

   // ------------------------------------------------------------
   // Output stage
   // ------------------------------------------------------------
   logic [1:0] relay_reg;
   logic [1:0] relay_next;
   logic [7:0] byte_next;

   always_comb begin
      relay_next = (module_active && wd_state_reg != WD_OFF) ? dly_out : 2'h0;
      byte_next = OUT_BYTE_RST;
      byte_next[OUT_CH1_BIT] = relay_next[0];
      byte_next[OUT_CH2_BIT] = relay_next[1];
   end

   logic [7:0] byte_reg;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         relay_reg <= 2'h0;
         byte_reg <= OUT_BYTE_RST;
      end else begin
         relay_reg <= relay_next;
         byte_reg <= byte_next;
      end
   end

   assign relay_out = relay_reg;
   assign out_byte = byte_reg;
   assign channel_active = {2{module_active}};
   assign err_active = err_reg;
   assign watchdog_expired = wd_err;
   assign outputs_off = (wd_state_reg == WD_OFF);

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_normal_pass: assert property (!sim_mode[0] && !err[0] && !negate[0]
      |=> cond_reg[0] == $past(bus_bits_reg[0]))
      else $error("normal mode did not pass bus value");
   a_sim_pass: assert property (sim_mode[1] && !err[1] && !negate[1]
      |=> cond_reg[1] == $past(sim_value[1]))
      else $error("simulation mode did not pass simulation value");
   a_wdog_error: assert property (wd_state_reg != WD_OK |=> err_active == 2'h3)
      else $error("watchdog expiry did not raise error");
   a_no_false_err: assert property (!sim_mode[0] && !bus_inv_reg[0]
      && wd_state_reg == WD_OK |=> !err_active[0])
      else $error("error raised without cause");
   a_current_mode: assert property (err[0] && err_mode[1:0] == ERR_CURRENT
      && !negate[0] |=> cond_reg[0] == $past(src[0]))
      else $error("current value mode changed the value");
   a_subst_mode: assert property (err[1] && err_mode[3:2] == ERR_SUBST
      |=> cond_reg[1] == ($past(subst_value[1]) ^ $past(negate[1])))
      else $error("substitute value not driven");
   a_last_hold: assert property (err[0] && err_mode[1:0] == ERR_LAST && !negate[0]
      |=> cond_reg[0] == $past(last_reg[0]))
      else $error("last valid value not held");
   a_negation: assert property (!err[1] && negate[1]
      |=> cond_reg[1] == !$past(src[1]))
      else $error("negation did not invert");
   a_on_filter: assert property ($rose(dly_out[0]) && on_delay_ms[DLY_W-1:0] != '0
      |-> $past(cond_reg[0], 1) && $past(cond_reg[0], 2))
      else $error("output rose without held input");
   a_off_stretch: assert property ($fell(dly_out[0]) |-> !$past(cond_reg[0]))
      else $error("output fell while input high");
   a_module_off: assert property (!module_active |-> channel_active == 2'h0
      ##1 relay_out == 2'h0)
      else $error("inactive module drove outputs");
   a_wdog_off: assert property (wd_state_reg == WD_OFF |=> relay_out == 2'h0)
      else $error("watchdog off state drove outputs");
   a_wdog_fails: assert property (wd_state_reg == WD_OK && !comm_ok && comm_fail
      && fail_cnt_reg == 2'h2 |=> wd_state_reg == WD_EXPIRED)
      else $error("third failure did not expire watchdog");
   a_byte_map: assert property (out_byte[7:2] == 6'h00 && out_byte[1:0] == relay_out)
      else $error("output byte layout wrong");
   a_sim_invalid: assert property (sim_mode[1] && sim_invalid[1] |=> err_active[1])
      else $error("simulation invalid did not raise error");

   c_wdog_off: cover property (wd_state_reg == WD_EXPIRED ##1 wd_state_reg == WD_OFF);
   c_sim_used: cover property (sim_mode[0] && !err[0] ##1 relay_out[0]);
   c_last_mode: cover property (err[1] && err_mode[3:2] == ERR_LAST);
   c_delayed_on: cover property ($rose(relay_out[0]) && on_delay_ms[DLY_W-1:0] != '0);

endmodule : relay_output_conditioner
`default_nettype wire

// [test/com_unit_model.sv]
// Behavioural com unit: output frames and attempt results
`timescale 1ns/10ps
`default_nettype none
module com_unit_model (
   input wire logic clk,
   output var logic [7:0] bus_out_byte,
   output var logic [1:0] bus_invalid,
   output var logic bus_strobe,
   output var logic comm_ok,
   output var logic comm_fail
);
   // Junk in the spare bits, changed every frame
   logic [5:0] fill_pat = 6'h2a;

   initial begin
      bus_out_byte = 8'h00;
      bus_invalid = 2'h3;
      bus_strobe = 1'b0;
      comm_ok = 1'b0;
      comm_fail = 1'b0;
   end

   task automatic send_frame(input logic [1:0] bits, input logic [1:0] inv);
      @(posedge clk);
      bus_out_byte <= {fill_pat, bits};
      bus_invalid <= inv;
      bus_strobe <= 1'b1;
      comm_ok <= 1'b1;
      @(posedge clk);
      // Lines released: show the inverse
      bus_out_byte <= ~{fill_pat, bits};
      bus_invalid <= ~inv;
      bus_strobe <= 1'b0;
      comm_ok <= 1'b0;
      fill_pat <= fill_pat + 6'h1;
   endtask : send_frame

   task automatic fail_attempt;
      @(posedge clk);
      comm_fail <= 1'b1;
      @(posedge clk);
      comm_fail <= 1'b0;
   endtask : fail_attempt
endmodule : com_unit_model
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for the relay output conditioner
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
   $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module tb_top import relay_pkg::*;;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic module_active = 1'b1;
   logic [7:0] bus_out_byte;
   logic [1:0] bus_invalid;
   logic bus_strobe;
   logic comm_ok;
   logic comm_fail;
   logic [1:0] sim_mode = 2'h0;
   logic [1:0] sim_value = 2'h0;
   logic [1:0] sim_invalid = 2'h0;
   logic [1:0] subst_value = 2'h2;
   logic [1:0] negate = 2'h0;
   logic [3:0] err_mode = 4'h0;
   logic [31:0] on_delay_ms = 32'h0;
   logic [31:0] off_delay_ms = 32'h0;
   logic [1:0] relay_out;
   logic [7:0] out_byte;
   logic [1:0] channel_active;
   logic [1:0] err_active;
   logic watchdog_expired;
   logic outputs_off;
   int n_errors = 0;
   int tests_run = 0;
   logic [1:0] exp_t [4] = '{2'h0, 2'h2, 2'h3, 2'h2};

   always #12.5 clk = ~clk;

   com_unit_model com (.clk(clk), .bus_out_byte(bus_out_byte), .bus_invalid(bus_invalid),
      .bus_strobe(bus_strobe), .comm_ok(comm_ok), .comm_fail(comm_fail));

   relay_output_conditioner #(.TICK_CYCLES(10)) DUT (.clk(clk), .sys_rst(sys_rst),
      .module_active(module_active), .bus_out_byte(bus_out_byte),
      .bus_invalid(bus_invalid), .bus_strobe(bus_strobe), .comm_ok(comm_ok),
      .comm_fail(comm_fail), .sim_mode(sim_mode), .sim_value(sim_value),
      .sim_invalid(sim_invalid), .subst_value(subst_value), .err_mode(err_mode),
      .negate(negate), .on_delay_ms(on_delay_ms), .off_delay_ms(off_delay_ms),
      .relay_out(relay_out), .out_byte(out_byte), .channel_active(channel_active),
      .err_active(err_active), .watchdog_expired(watchdog_expired),
      .outputs_off(outputs_off));

   task automatic close_out;
      if (n_errors == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   task automatic wait_out(input logic [1:0] v, input int lim);
      int k;
      k = 0;
      while (relay_out !== v && k < lim) begin
         step(1);
         k++;
      end
      if (k >= lim) begin
         n_errors++;
         close_out;
      end
   endtask : wait_out

   // ---------------------------
   // Scenarios
   // ---------------------------
   task automatic t_normal;
      for (int v = 0; v < 4; v++) begin
         com.send_frame(v[1:0], 2'h0);
         step(4);
         `CHK(relay_out, v[1:0])
         `CHK(out_byte, {6'h0, v[1:0]})
         `CHK(err_active, 2'h0)
      end
   endtask : t_normal

   task automatic t_sim;
      @(posedge clk);
      sim_mode <= 2'h3;
      sim_value <= 2'h1;
      sim_invalid <= 2'h2;
      err_mode <= 4'h5;
      com.send_frame(2'h2, 2'h0);
      step(5);
      `CHK(relay_out, 2'h3)
      `CHK(err_active, 2'h2)
      @(posedge clk);
      err_mode <= 4'h0;
      step(5);
      `CHK(relay_out, 2'h1)
      @(posedge clk);
      sim_mode <= 2'h0;
      sim_invalid <= 2'h0;
   endtask : t_sim

   task automatic t_errs;
      for (int m = 0; m < 4; m++) begin
         @(posedge clk);
         err_mode <= {m[1:0], m[1:0]};
         com.send_frame(2'h3, 2'h0);
         com.send_frame(2'h0, 2'h3);
         step(5);
         `CHK(relay_out, exp_t[m])
         `CHK(err_active, 2'h3)
      end
   endtask : t_errs

   task automatic t_negate;
      @(posedge clk);
      negate <= 2'h3;
      com.send_frame(2'h1, 2'h0);
      step(5);
      `CHK(relay_out, 2'h2)
      com.send_frame(2'h1, 2'h3);
      step(5);
      `CHK(relay_out, 2'h1)
      @(posedge clk);
      negate <= 2'h0;
   endtask : t_negate

   task automatic t_active;
      @(posedge clk);
      module_active <= 1'b0;
      com.send_frame(2'h3, 2'h0);
      step(5);
      `CHK(channel_active, 2'h0)
      `CHK(relay_out, 2'h0)
      @(posedge clk);
      module_active <= 1'b1;
      step(5);
      `CHK(channel_active, 2'h3)
      `CHK(relay_out, 2'h3)
   endtask : t_active

   task automatic t_delays;
      logic [1:0] hi;
      hi = 2'h0;
      @(posedge clk);
      sim_mode <= 2'h3;
      sim_value <= 2'h0;
      on_delay_ms <= {16'd3, 16'd3};
      step(60);
      @(posedge clk);
      sim_value <= 2'h3;
      repeat (8) @(posedge clk);
      sim_value <= 2'h0;
      repeat (60) begin
         step(1);
         hi = hi | relay_out;
      end
      `CHK(hi, 2'h0)
      @(posedge clk);
      sim_value <= 2'h3;
      step(10);
      `CHK(relay_out, 2'h0)
      wait_out(2'h3, 40);
      `CHK(relay_out, 2'h3)
      @(posedge clk);
      on_delay_ms <= 32'h0;
      off_delay_ms <= {16'd3, 16'd3};
      sim_value <= 2'h0;
      step(10);
      `CHK(relay_out, 2'h3)
      wait_out(2'h0, 40);
      `CHK(relay_out, 2'h0)
      @(posedge clk);
      off_delay_ms <= 32'h0;
      sim_mode <= 2'h0;
   endtask : t_delays

   task automatic t_watchdog;
      int k;
      k = 0;
      @(posedge clk);
      err_mode <= 4'h5;
      subst_value <= 2'h3;
      com.send_frame(2'h0, 2'h0);
      com.fail_attempt;
      com.fail_attempt;
      step(2);
      `CHK(watchdog_expired, 1'b0)
      com.fail_attempt;
      step(1);
      `CHK(watchdog_expired, 1'b1)
      step(4);
      `CHK(err_active, 2'h3)
      `CHK(relay_out, 2'h3)
      while (outputs_off !== 1'b1 && k < 5200) begin
         step(1);
         k++;
      end
      if (k >= 5200) begin
         n_errors++;
         close_out;
      end
      `CHK(k >= 4980, 1'b1)
      step(2);
      `CHK(relay_out, 2'h0)
      `CHK(out_byte, 8'h00)
      com.send_frame(2'h0, 2'h0);
      step(2);
      `CHK(watchdog_expired, 1'b0)
      `CHK(outputs_off, 1'b0)
   endtask : t_watchdog

   initial begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      step(2);
      `CHK(relay_out, 2'h0)
      `CHK(err_active, 2'h3)
      t_normal;
      t_sim;
      t_errs;
      t_negate;
      t_active;
      t_delays;
      t_watchdog;
      close_out;
   end
endmodule : tb_top
`default_nettype wire
